// ### ods_host_model.sv
`timescale 1ns/1ps
// =============================================
// Host side: answers status queries
module ods_host_model (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_req,
	input wire logic [1:0] i_msg_status,
	input wire logic i_phase_locked,
	output logic [2:0] o_rsp_q
);
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			o_rsp_q <= 3'h0;
		end
		else if (i_req)
		begin
			o_rsp_q <= {i_phase_locked, i_msg_status};
		end
	end
endmodule

// ### ods_pkg.sv
// =============================================
// Shared constants for the discipline controller
package ods_pkg;

	// =============================================
	// Timebase
	localparam int CLK_PERIOD_NS = 100;
	localparam longint SEC_NS = 64'h3B9ACA00;
	localparam int TICK_CYCLES = int'(SEC_NS / CLK_PERIOD_NS);
	localparam int FAST_DIV = 8;

	// =============================================
	// Coast alarm and survey
	localparam int COAST_MINUTES = 60;
	localparam int COAST_SECONDS = COAST_MINUTES * 60;
	localparam int SURVEY_MEAS = 10000;

	// =============================================
	// Settings and reset values
	localparam logic [2:0] BAUD_1200 = 3'h0;
	localparam logic [2:0] BAUD_2400 = 3'h1;
	localparam logic [2:0] BAUD_4800 = 3'h2;
	localparam logic [2:0] BAUD_9600 = 3'h3;
	localparam logic [2:0] BAUD_19200 = 3'h4;
	localparam logic [2:0] BAUD_38400 = 3'h5;
	localparam logic [2:0] BAUD_RESET = BAUD_9600;
	localparam logic TMODE_DYNAMIC = 1'h0;
	localparam logic TMODE_STATIC = 1'h1;
	localparam logic TMODE_RESET = TMODE_DYNAMIC;

	// =============================================
	// Mode codes and status bit positions
	localparam logic [2:0] MODE_CODE_WARM = 3'h1;
	localparam logic [2:0] MODE_CODE_CTUNE = 3'h2;
	localparam logic [2:0] MODE_CODE_CHOLD = 3'h3;
	localparam logic [2:0] MODE_CODE_FTUNE = 3'h4;
	localparam logic [2:0] MODE_CODE_FHOLD = 3'h5;
	localparam int STAT_VALID_BIT = 0;
	localparam int STAT_ALARM_BIT = 1;

	// =============================================
	// Pin synchroniser slots
	localparam int PIN_OVEN = 0;
	localparam int PIN_ANT = 1;
	localparam int PIN_OUTF = 2;
	localparam int PIN_VCXO = 3;
	localparam int PIN_N = 4;

	typedef enum logic [2:0] {
		ODS_WARM,
		ODS_CTUNE,
		ODS_CHOLD,
		ODS_FTUNE,
		ODS_FHOLD
	} ods_mode_type;

endpackage

// ### ods_status_fsm.sv
`timescale 1ns/1ps
// Function
// [R01] Valid after warm-up enters coarse tuning
// [R02] Coarse done enters fine tuning, ready
// [R03] Time valid: ready flashes, alarm off
// [R04] Time functions and pps gated by valid
// [R05] Crystal variant ready at valid, no tuning
// [R06] Warm-up applies no tuning
// [R07] Error in coarse: hold, reset tuning
// [R08] Error in fine: hold, both flash
// [R09] Report phase lock to pps
// [R10] Static mode valid while satellite tracked
// [R11] Survey averages 10000 fixes, goes static
// [R12] Valid shown in status, response, indicators
// [R13] Coast in coarse: ready off, alarm flashes
// [R14] Coast in fine: alarm and ready flash
// [R15] Sixty minutes coast raises coast alarm
// [R16] Coast with fault flashes power
// [R17] Coast alarm cleared when valid regained
// [R18] Leave coast when timing data returns
// [R19] Baud rates six choices, default 9600
// [R20] Timing mode static/dynamic, default dynamic
// [R21] Valid needs fix and utc offset
// [R22] Power-up fast flash, then power, alarm
// [R23] Mode as 3-bit code 1 to 5
// [R24] All flashing from one timebase
module ods_status_fsm #(
	parameter int TICK_CYCLES = ods_pkg::TICK_CYCLES,
	parameter int COAST_SECONDS = ods_pkg::COAST_SECONDS,
	parameter int SURVEY_MEAS = ods_pkg::SURVEY_MEAS,
	parameter int SAT_W = 4
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_oven_ready,
	input wire logic i_ant_fault,
	input wire logic i_out_fault,
	input wire logic i_vcxo_variant,
	input wire logic i_fix_valid,
	input wire logic i_utc_offset_rcvd,
	input wire logic i_timing_ok,
	input wire logic [SAT_W-1:0] i_sats_tracked,
	input wire logic i_coarse_done,
	input wire logic i_phase_locked,
	input wire logic i_survey_req,
	input wire logic i_pos_meas,
	input wire logic i_set_timing_mode,
	input wire logic i_timing_static,
	input wire logic i_set_baud,
	input wire logic [2:0] i_baud_sel,
	output logic [2:0] o_osc_mode,
	output logic o_time_valid,
	output logic o_coast,
	output logic o_coast_alarm,
	output logic o_alarm_out,
	output logic o_ref_ready,
	output logic o_tune_en,
	output logic o_tune_reset,
	output logic o_holdover,
	output logic o_phase_locked,
	output logic o_time_funcs_en,
	output logic o_pps_locked,
	output logic [1:0] o_msg_status,
	output logic o_timing_static,
	output logic o_surveying,
	output logic [2:0] o_baud_sel,
	output logic o_led_ready,
	output logic o_led_alarm,
	output logic o_led_power
);
	localparam int CW = $clog2(COAST_SECONDS + 1);
	localparam int MW = $clog2(SURVEY_MEAS + 1);

	generate
		if (COAST_SECONDS < 1 || SURVEY_MEAS < 1 || SAT_W < 1)
		begin : g_chk
			$error("Counts and widths must be at least one");
		end
	endgenerate

	ods_tb_if tb ();

	ods_timebase #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tb (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.tb(tb.src)
	);

	// =============================================
	// Pin synchronisers
	logic [ods_pkg::PIN_N-1:0] pin_s1_q;
	logic [ods_pkg::PIN_N-1:0] pin_s2_q;
	logic [ods_pkg::PIN_N-1:0] pins;

	assign pins = {i_vcxo_variant, i_out_fault, i_ant_fault, i_oven_ready};

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
		end
		else
		begin
			pin_s1_q <= pins;
			pin_s2_q <= pin_s1_q;
		end
	end

	logic oven_ok;
	logic hw_fault;
	logic vcxo;

	assign oven_ok = pin_s2_q[ods_pkg::PIN_OVEN];
	assign hw_fault = pin_s2_q[ods_pkg::PIN_ANT] | pin_s2_q[ods_pkg::PIN_OUTF];
	assign vcxo = pin_s2_q[ods_pkg::PIN_VCXO];

	// =============================================
	// Timing mode, survey and baud settings
	logic static_q;
	logic survey_q;
	logic [MW-1:0] meas_q;
	logic [2:0] baud_q;

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			static_q <= ods_pkg::TMODE_RESET;
			survey_q <= 1'b0;
			meas_q <= '0;
		end
		// [R20] Direct mode write
		else if (i_set_timing_mode)
		begin
			static_q <= i_timing_static;
			survey_q <= 1'b0;
		end
		else if (i_survey_req && !static_q)
		begin
			survey_q <= 1'b1;
			meas_q <= '0;
		end
		// [R11] Count fixes, switch static
		else if (survey_q && i_pos_meas)
		begin
			if (meas_q == MW'(SURVEY_MEAS - 1))
			begin
				static_q <= ods_pkg::TMODE_STATIC;
				survey_q <= 1'b0;
			end
			else
				meas_q <= meas_q + MW'(1);
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
			baud_q <= ods_pkg::BAUD_RESET;
		// [R19] Legal codes only
		else if (i_set_baud && i_baud_sel <= ods_pkg::BAUD_38400)
			baud_q <= i_baud_sel;
	end

	// =============================================
	// Time valid and coast
	logic avail;
	logic tv_q;
	logic ever_q;
	logic coast;

	// [R10] Static needs one satellite
	assign avail = static_q ? (i_sats_tracked != '0) : i_timing_ok;

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
			tv_q <= 1'b0;
		// [R21] Fix and utc offset
		else if (!tv_q)
			tv_q <= i_fix_valid && i_utc_offset_rcvd && avail;
		// [R18] Hold while timing flows
		else
			tv_q <= avail;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
			ever_q <= 1'b0;
		else if (tv_q)
			ever_q <= 1'b1;
	end

	assign coast = ever_q && !tv_q;

	// =============================================
	// Coast alarm timer
	logic [CW-1:0] coast_cnt_q;
	logic alarm_q;

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b || !coast)
			coast_cnt_q <= '0;
		else if (tb.tick && coast_cnt_q != CW'(COAST_SECONDS))
			coast_cnt_q <= coast_cnt_q + CW'(1);
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
			alarm_q <= 1'b0;
		// [R17] Clear on valid
		else if (tv_q)
			alarm_q <= 1'b0;
		// [R15] Sixty continuous minutes
		else if (coast && tb.tick && coast_cnt_q == CW'(COAST_SECONDS - 1))
			alarm_q <= 1'b1;
	end

	// =============================================
	// Oscillator mode machine
	ods_pkg::ods_mode_type st_q;
	logic tune_rst_q;

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
			st_q <= ods_pkg::ODS_WARM;
		else
		begin
			unique case (st_q)
				// [R01] Valid after warm-up
				ods_pkg::ODS_WARM:
					if (!vcxo && oven_ok && tv_q)
						st_q <= ods_pkg::ODS_CTUNE;
				// [R07] Lost timing holds
				ods_pkg::ODS_CTUNE:
					if (!tv_q)
						st_q <= ods_pkg::ODS_CHOLD;
					else if (i_coarse_done)
						st_q <= ods_pkg::ODS_FTUNE;
				ods_pkg::ODS_CHOLD:
					if (tv_q)
						st_q <= ods_pkg::ODS_CTUNE;
				// [R08] Lost timing holds
				ods_pkg::ODS_FTUNE:
					if (!tv_q)
						st_q <= ods_pkg::ODS_FHOLD;
				ods_pkg::ODS_FHOLD:
					if (tv_q)
						st_q <= ods_pkg::ODS_FTUNE;
			endcase
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
			tune_rst_q <= 1'b0;
		// [R07] Reset stored tuning
		else
			tune_rst_q <= (st_q == ods_pkg::ODS_CTUNE) && !tv_q;
	end

	function automatic logic [2:0] mode_code(ods_pkg::ods_mode_type s);
		unique case (s)
			ods_pkg::ODS_WARM: mode_code = ods_pkg::MODE_CODE_WARM;
			ods_pkg::ODS_CTUNE: mode_code = ods_pkg::MODE_CODE_CTUNE;
			ods_pkg::ODS_CHOLD: mode_code = ods_pkg::MODE_CODE_CHOLD;
			ods_pkg::ODS_FTUNE: mode_code = ods_pkg::MODE_CODE_FTUNE;
			ods_pkg::ODS_FHOLD: mode_code = ods_pkg::MODE_CODE_FHOLD;
		endcase
	endfunction

	logic ref_ready;
	logic in_fine;

	assign in_fine = st_q == ods_pkg::ODS_FTUNE;
	// [R02] [R05] Ready in fine or crystal variant
	assign ref_ready = tv_q && (vcxo || in_fine);

	// =============================================
	// Front-panel indicators
	logic powerup_q;
	logic led_ready_q;
	logic led_alarm_q;
	logic led_power_q;
	logic led_ready_d;
	logic led_alarm_d;
	logic led_power_d;

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
			powerup_q <= 1'b1;
		else if (tb.tick)
			powerup_q <= 1'b0;
	end

	always_comb
	begin
		// [R24] One shared flash source
		led_power_d = 1'b1;
		led_alarm_d = 1'b1;
		led_ready_d = 1'b0;
		// [R22] Power-up flash
		if (powerup_q)
		begin
			led_power_d = tb.flash_fast;
			led_alarm_d = tb.flash_fast;
			led_ready_d = tb.flash_fast;
		end
		else
		begin
			// [R16] Fault during coast
			if (coast && hw_fault)
				led_power_d = tb.flash_slow;
			// [R15] Alarm steady, ready off
			if (alarm_q)
			begin
				led_alarm_d = 1'b1;
				led_ready_d = 1'b0;
			end
			// [R13] [R14] Coast indication
			else if (coast)
			begin
				led_alarm_d = tb.flash_slow;
				led_ready_d = (in_fine || st_q == ods_pkg::ODS_FHOLD)
					? tb.flash_slow : 1'b0;
			end
			// [R03] Valid indication
			else if (tv_q)
			begin
				led_alarm_d = 1'b0;
				led_ready_d = ref_ready ? 1'b1 : tb.flash_slow;
			end
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			led_ready_q <= 1'b0;
			led_alarm_q <= 1'b0;
			led_power_q <= 1'b0;
		end
		else
		begin
			led_ready_q <= led_ready_d;
			led_alarm_q <= led_alarm_d;
			led_power_q <= led_power_d;
		end
	end

	// =============================================
	// Outputs
	// [R23] Mode code 1 to 5
	assign o_osc_mode = mode_code(st_q);
	assign o_time_valid = tv_q;
	assign o_coast = coast;
	assign o_coast_alarm = alarm_q;
	assign o_alarm_out = alarm_q;
	assign o_ref_ready = ref_ready;
	// [R06] Tune only in tuning modes
	assign o_tune_en = tv_q && (in_fine || st_q == ods_pkg::ODS_CTUNE);
	assign o_tune_reset = tune_rst_q;
	assign o_holdover = st_q == ods_pkg::ODS_FHOLD;
	// [R09] Phase lock report
	assign o_phase_locked = in_fine && tv_q && i_phase_locked;
	// [R04] Gated by time valid
	assign o_time_funcs_en = tv_q;
	assign o_pps_locked = tv_q;
	// [R12] Status byte bits
	assign o_msg_status[ods_pkg::STAT_VALID_BIT] = tv_q;
	assign o_msg_status[ods_pkg::STAT_ALARM_BIT] = alarm_q;
	assign o_timing_static = static_q;
	assign o_surveying = survey_q;
	assign o_baud_sel = baud_q;
	assign o_led_ready = led_ready_q;
	assign o_led_alarm = led_alarm_q;
	assign o_led_power = led_power_q;

	// =============================================
	// Assertions
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);

	property p_warm_idle;
		st_q == ods_pkg::ODS_WARM |-> !o_tune_en && o_osc_mode == 3'h1;
	endproperty
	a_warm_idle: assert property (p_warm_idle) else $error("tuning in warm-up"); // [R06]

	property p_coarse_entry;
		st_q == ods_pkg::ODS_WARM && oven_ok && tv_q && !vcxo
			|=> o_osc_mode == 3'h2 && (o_tune_en || !tv_q);
	endproperty
	a_coarse_entry: assert property (p_coarse_entry) else $error("no coarse entry"); // [R01]

	property p_fine_ready;
		st_q == ods_pkg::ODS_CTUNE && tv_q && i_coarse_done
			|=> o_osc_mode == 3'h4 ##1 (!tv_q || !$past(tv_q)
			|| $past(powerup_q) || (led_ready_q && o_ref_ready));
	endproperty
	a_fine_ready: assert property (p_fine_ready) else $error("fine not ready"); // [R02]

	property p_valid_leds;
		!powerup_q && !alarm_q && tv_q && !ref_ready |=> !led_alarm_q;
	endproperty
	a_valid_leds: assert property (p_valid_leds) else $error("alarm lit when valid"); // [R03]

	property p_coarse_hold;
		st_q == ods_pkg::ODS_CTUNE && !tv_q
			|=> o_osc_mode == 3'h3 && o_tune_reset && !o_tune_en;
	endproperty
	a_coarse_hold: assert property (p_coarse_hold) else $error("coarse hold wrong"); // [R07]

	property p_fine_hold_leds;
		st_q == ods_pkg::ODS_FHOLD && !alarm_q && !powerup_q && !tv_q
			|=> led_alarm_q == $past(tb.flash_slow)
			&& led_ready_q == $past(tb.flash_slow);
	endproperty
	a_fine_hold_leds: assert property (p_fine_hold_leds) else $error("fine hold leds"); // [R08]

	property p_coast_alarm;
		coast && tb.tick && coast_cnt_q == CW'(COAST_SECONDS - 1)
			|=> o_alarm_out ##1 (!tv_q || powerup_q || (led_alarm_q && !led_ready_q));
	endproperty
	a_coast_alarm: assert property (p_coast_alarm) else $error("coast alarm missing"); // [R15]

	property p_alarm_clear;
		$rose(tv_q) |=> !o_coast_alarm;
	endproperty
	a_alarm_clear: assert property (p_alarm_clear) else $error("alarm kept"); // [R17]

	property p_static_valid;
		tv_q && static_q && i_sats_tracked != '0 |=> tv_q;
	endproperty
	a_static_valid: assert property (p_static_valid) else $error("static dropped"); // [R10]

	property p_survey_done;
		survey_q && i_pos_meas && !i_set_timing_mode && !i_survey_req
			&& meas_q == MW'(SURVEY_MEAS - 1)
			|=> o_timing_static && !o_surveying;
	endproperty
	a_survey_done: assert property (p_survey_done) else $error("survey end"); // [R11]

	c_fine: cover property (st_q == ods_pkg::ODS_FTUNE && tv_q);
	c_fhold: cover property (st_q == ods_pkg::ODS_FHOLD);
	c_alarm: cover property ($rose(alarm_q));
	c_survey: cover property ($fell(survey_q) && static_q);
endmodule

// ### ods_status_fsm_test.sv
`timescale 1ns/1ps
module ods_status_fsm_test;
	logic clk;
	logic rst_b = 1'h0;
	logic oven = 1'h0, ant = 1'h0, outf = 1'h0, vcxo = 1'h0;
	logic fix = 1'h0, utc = 1'h0, tok = 1'h0, cdone = 1'h0, plock = 1'h0;
	logic sreq = 1'h0, pmeas = 1'h0, setm = 1'h0, tst = 1'h0, setb = 1'h0;
	logic hreq = 1'h0;
	logic [3:0] sats = 4'h0;
	logic [2:0] bsel = 3'h0;
	logic [2:0] mode, baud, rsp;
	logic [1:0] msg;
	logic tv, coast, calm, aout, rdy, tune, trst, hold, plk, funcs, pps;
	logic tst_o, surv, lr, la, lp;
	int err_count = 0;
	int num_checks = 0;
	int tr, ta, tp, dif, k;

	ods_status_fsm #(.TICK_CYCLES(64), .COAST_SECONDS(3), .SURVEY_MEAS(4))
		i_ods_status_fsm (.i_clk(clk), .i_rst_b(rst_b), .i_oven_ready(oven),
		.i_ant_fault(ant), .i_out_fault(outf), .i_vcxo_variant(vcxo),
		.i_fix_valid(fix), .i_utc_offset_rcvd(utc), .i_timing_ok(tok),
		.i_sats_tracked(sats), .i_coarse_done(cdone),
		.i_phase_locked(plock), .i_survey_req(sreq), .i_pos_meas(pmeas),
		.i_set_timing_mode(setm), .i_timing_static(tst), .i_set_baud(setb),
		.i_baud_sel(bsel), .o_osc_mode(mode), .o_time_valid(tv),
		.o_coast(coast), .o_coast_alarm(calm), .o_alarm_out(aout),
		.o_ref_ready(rdy), .o_tune_en(tune), .o_tune_reset(trst),
		.o_holdover(hold), .o_phase_locked(plk), .o_time_funcs_en(funcs),
		.o_pps_locked(pps), .o_msg_status(msg), .o_timing_static(tst_o),
		.o_surveying(surv), .o_baud_sel(baud), .o_led_ready(lr),
		.o_led_alarm(la), .o_led_power(lp));

	ods_host_model i_ods_host_model (.i_clk(clk), .i_rst_b(rst_b),
		.i_req(hreq), .i_msg_status(msg), .i_phase_locked(plk),
		.o_rsp_q(rsp));

	initial
	begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end

	// =============================================
	// Helpers
	task chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	task watch(input int n);
		logic r, a, p;
		{tr, ta, tp, dif} = '0;
		{r, a, p} = {lr, la, lp};
		repeat (n)
		begin
			@(negedge clk);
			tr += int'(lr !== r);
			ta += int'(la !== a);
			tp += int'(lp !== p);
			dif += int'(lr !== la);
			{r, a, p} = {lr, la, lp};
		end
	endtask

	task query();
		@(posedge clk);
		hreq <= 1'h1;
		@(posedge clk);
		hreq <= 1'h0;
		@(negedge clk);
	endtask

	task give_verdict();
		$display("Checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// =============================================
	// Scenarios
	task t_reset();
		cyc(2);
		chk("baud", baud, 3'h3);
		chk("static", tst_o, 1'h0);
		chk("mode", mode, 3'h1);
		watch(40);
		chk("power fast", tp > 0, 1'h1);
		chk("all fast", {tr > 0, ta > 0, dif == 0}, 3'h7);
		cyc(40);
		chk("leds settled", {lr, la, lp}, 3'h3);
	endtask

	task t_baud();
		logic [2:0] e;
		e = 3'h3;
		for (k = 0; k < 8; k++)
		begin
			@(posedge clk);
			setb <= 1'h1;
			bsel <= k[2:0];
			@(posedge clk);
			setb <= 1'h0;
			e = (k < 6) ? k[2:0] : e;
			cyc(0);
			chk("baud code", baud, e);
		end
	endtask

	task t_warm();
		@(posedge clk);
		{fix, tok} <= 2'h3;
		cyc(4);
		chk("valid no utc", tv, 1'h0);
		@(posedge clk);
		utc <= 1'h1;
		cyc(4);
		chk("valid", tv, 1'h1);
		chk("funcs pps", {funcs, pps}, 2'h3);
		chk("warm mode", {mode, tune}, 4'h2);
		chk("alarm led off", la, 1'h0);
		query();
		chk("host valid", rsp[0], 1'h1);
		watch(70);
		chk("ready flash", tr > 0, 1'h1);
		@(posedge clk);
		oven <= 1'h1;
		cyc(6);
		chk("coarse", {mode, tune}, 4'h5);
	endtask

	task t_coarse_loss();
		@(posedge clk);
		tok <= 1'h0;
		cyc(1);
		chk("coast", {tv, coast, funcs}, 3'h2);
		k = 0;
		repeat (4)
		begin
			cyc(0);
			k += int'(trst === 1'h1);
			@(posedge clk);
		end
		chk("tune reset once", k, 1);
		chk("coarse hold", {mode, tune}, 4'h6);
		watch(70);
		chk("coast leds", {tr > 0, lr, ta > 0}, 3'h1);
		chk("power steady", tp, 0);
		@(posedge clk);
		tok <= 1'h1;
		cyc(4);
		chk("regain", {tv, mode}, 4'hA);
	endtask

	task t_fine();
		@(posedge clk);
		cdone <= 1'h1;
		plock <= 1'h1;
		cyc(3);
		chk("fine ready", {mode, rdy}, 4'h9);
		chk("locked", plk, 1'h1);
		query();
		chk("host lock", rsp[2], 1'h1);
		watch(8);
		chk("ready steady", tr, 0);
		chk("ready lit", lr, 1'h1);
		@(posedge clk);
		{cdone, tok, ant} <= 3'h1;
		cyc(4);
		chk("fine hold", {mode, hold}, 4'hB);
		watch(100);
		chk("both flash", {tr > 0, ta > 0}, 2'h3);
		chk("in phase", dif, 0);
		chk("power flash", tp > 0, 1'h1);
		chk("alarm early", calm, 1'h0);
		k = 0;
		while (calm !== 1'h1 && k < 300)
		begin
			cyc(0);
			k++;
			@(posedge clk);
		end
		cyc(2);
		chk("coast alarm", {calm, aout, la, lr}, 4'hE);
		query();
		chk("host alarm", rsp[1], 1'h1);
		@(posedge clk);
		{tok, ant} <= 2'h2;
		cyc(3);
		chk("alarm clear", {calm, tv, mode}, 5'h0C);
	endtask

	task t_survey();
		@(posedge clk);
		sreq <= 1'h1;
		sats <= 4'h1;
		@(posedge clk);
		sreq <= 1'h0;
		cyc(0);
		chk("surveying", surv, 1'h1);
		@(posedge clk);
		pmeas <= 1'h1;
		repeat (3) @(posedge clk);
		pmeas <= 1'h0;
		cyc(1);
		chk("not yet", tst_o, 1'h0);
		@(posedge clk);
		pmeas <= 1'h1;
		@(posedge clk);
		pmeas <= 1'h0;
		cyc(0);
		chk("survey done", {tst_o, surv}, 2'h2);
		@(posedge clk);
		{tok, sats} <= 5'h01;
		cyc(4);
		chk("static valid", {tv, coast}, 2'h2);
		@(posedge clk);
		sats <= 4'h0;
		cyc(3);
		chk("static lost", tv, 1'h0);
		@(posedge clk);
		{setm, tst} <= 2'h2;
		@(posedge clk);
		setm <= 1'h0;
		cyc(0);
		chk("dynamic", tst_o, 1'h0);
	endtask

	task t_vcxo();
		@(posedge clk);
		{rst_b, vcxo, oven, tok} <= 4'h7;
		repeat (16) @(posedge clk);
		rst_b <= 1'h1;
		cyc(2);
		chk("baud reset", baud, 3'h3);
		chk("static reset", tst_o, 1'h0);
		cyc(6);
		chk("crystal ready", {tv, rdy, mode}, 5'h19);
		chk("crystal funcs", {funcs, tune}, 2'h2);
	endtask

	initial
	begin
		repeat (16) @(posedge clk);
		rst_b <= 1'h1;
		t_reset();
		t_baud();
		t_warm();
		t_coarse_loss();
		t_fine();
		t_survey();
		t_vcxo();
		give_verdict();
	end

	initial
	begin
		#(100 * 20000);
		err_count++;
		give_verdict();
	end
endmodule

// ### ods_tb_if.sv
`timescale 1ns/1ps
// =============================================
// Timebase carrier between timebase and controller
interface ods_tb_if;
	logic tick;
	logic flash_slow;
	logic flash_fast;
	modport src (output tick, output flash_slow, output flash_fast);
	modport snk (input tick, input flash_slow, input flash_fast);
endinterface

// ### ods_timebase.sv
`timescale 1ns/1ps
// =============================================
// Common divided timebase for ticks and flashing
module ods_timebase #(
	parameter int TICK_CYCLES = ods_pkg::TICK_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	ods_tb_if.src tb
);
	localparam int FAST_CYCLES = TICK_CYCLES / (2 * ods_pkg::FAST_DIV);
	localparam int W = $clog2(TICK_CYCLES + 1);

	generate
		if (FAST_CYCLES < 1)
		begin : g_chk
			$error("TICK_CYCLES too small for fast flash");
		end
	endgenerate

	logic [W-1:0] sec_q;
	logic [W-1:0] fcnt_q;
	logic tick_q;
	logic slow_q;
	logic fast_q;

	// =============================================
	// One second divider
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			sec_q <= '0;
			tick_q <= 1'b0;
		end
		else if (sec_q == W'(TICK_CYCLES - 1))
		begin
			sec_q <= '0;
			tick_q <= 1'b1;
		end
		else
		begin
			sec_q <= sec_q + W'(1);
			tick_q <= 1'b0;
		end
	end

	// =============================================
	// Slow and fast flash phases
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
			slow_q <= 1'b1;
		else
			slow_q <= sec_q < W'(TICK_CYCLES / 2);
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			fcnt_q <= '0;
			fast_q <= 1'b1;
		end
		else if (fcnt_q == W'(FAST_CYCLES - 1))
		begin
			fcnt_q <= '0;
			fast_q <= !fast_q;
		end
		else
			fcnt_q <= fcnt_q + W'(1);
	end

	assign tb.tick = tick_q;
	assign tb.flash_slow = slow_q;
	assign tb.flash_fast = fast_q;
endmodule
